// file: shared/cgt_map.svh
// Constants for the counter channel timing core
`ifndef CGT_MAP_SVH
`define CGT_MAP_SVH
`define CGT_CNT_W 16
`define CGT_ZERO 16'h0000
`define CGT_ONE 16'h0001
`define CGT_TWO 16'h0002
`define CGT_BIN_TOP 16'hFFFF
`define CGT_BCD_TOP 16'h9999
`define CGT_BCD_NINE 4'h9
`define CGT_BCD_DIGITS 4
`define CGT_OUT_INIT 1'b1
`endif

// file: shared/cgt_pkg.sv
// Types shared by the counter channel timing core
package cgt_pkg;
  typedef enum logic [2:0] {
    CGT_M0, CGT_M1, CGT_M2, CGT_M3, CGT_M4, CGT_M5
  } cgt_mode_t;
endpackage : cgt_pkg

// file: rtl/cgt_edge_sync.sv
// Clock edge and gate trigger detector for the counter channel
`include "cgt_map.svh"
module cgt_edge_sync
  import cgt_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Raw inputs
  input wire logic cnt_clk,
  input wire logic gate_in,
  input wire logic arm_clr,
  // Events
  output logic cclk_rise,
  output logic cclk_fall,
  output logic gate_lvl,
  output logic trig_seen
);
  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  typedef struct packed {
    logic clk_d;   // Previous counter clock level
    logic gate_d;  // Previous gate level
    logic trig;    // Edge catch flip-flop
    logic lvl;     // Gate level captured at rising clock
    logic rise;    // Rising counter clock pulse
    logic fall;    // Falling counter clock pulse
    logic tsmp;    // Trigger sampled at rising clock
  } cgt_es_t;
  cgt_es_t s_reg, s_next;

  // Next state: inputs taken as synchronous, so no extra stages
  always_comb
  begin
    s_next = s_reg;
    s_next.clk_d = cnt_clk;
    s_next.gate_d = gate_in;
    s_next.rise = cnt_clk & ~s_reg.clk_d;
    s_next.fall = ~cnt_clk & s_reg.clk_d;
    s_next.tsmp = 1'b0;
    // Gate sampled on every rising counter clock edge
    if (cnt_clk & ~s_reg.clk_d)
    begin
      s_next.lvl = gate_in;
      s_next.tsmp = s_reg.trig | (gate_in & ~s_reg.gate_d);
      s_next.trig = 1'b0;
    end
    else if (gate_in & ~s_reg.gate_d)
      s_next.trig = 1'b1;
    // Mode write drops a pending or new trigger on the same edge, unless a rising clock samples it in that cycle
    if (arm_clr)
      s_next.trig = 1'b0;
  end

  // Register the state
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign cclk_rise = s_reg.rise;
  assign cclk_fall = s_reg.fall;
  assign gate_lvl = s_reg.lvl;
  assign trig_seen = s_reg.tsmp;

  // Short trigger between clock edges is still reported
  a_trig_caught: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (s_reg.trig && !arm_clr && cnt_clk && !s_reg.clk_d) |=> s_reg.tsmp)
    else $error("pending trigger not sampled");
  // Gate level latched on every rising counter clock
  a_gate_sample: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (cnt_clk && !s_reg.clk_d) |=> (s_reg.lvl == $past(gate_in)))
    else $error("gate level not sampled at rising clock");
endmodule : cgt_edge_sync

// file: rtl/cgt_counter.sv
// Counter channel core: mode setup, gating, load, decrement and wrap
// How it works
// - Mode write resets logic, output initialised now
// - Gate sampled every rising counter clock
// - Modes 0,2,3,4: gate level enables counting
// - Modes 1,2,3,5: gate edge sets trigger
// - Load and decrement only on falling clock
// - Zero count means 65536 or 10000
// - Modes 0,1,4,5 wrap to FFFF/9999
// - Modes 2,3 reload initial count automatically
// - Minimum count two in modes 2,3
`include "cgt_map.svh"
module cgt_counter
  import cgt_pkg::*;
#(
  parameter int CNT_W = `CGT_CNT_W
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Mode setup strobe and fields
  input wire logic mode_wr,
  input wire logic [2:0] mode_sel,
  input wire logic bcd_sel,
  // Count write strobe and value
  input wire logic count_wr,
  input wire logic [CNT_W-1:0] count_val,
  // Counting inputs
  input wire logic cnt_clk,
  input wire logic gate_in,
  // Results
  output logic cnt_out,
  output logic [CNT_W-1:0] count_now,
  output logic count_err
);
  // --------------------------------------------------------------
  // Types and helpers
  // --------------------------------------------------------------
  typedef struct packed {
    cgt_mode_t mode;               // Active mode
    logic bcd;                     // Decimal coded counting
    logic [CNT_W-1:0] init;        // Programmed initial count
    logic [CNT_W-1:0] cnt;         // Counting element
    logic have_cnt;                // A count waits for loading
    logic run;                     // Element holds a live count
    logic armed;                   // Edge modes: trigger seen
    logic out;                     // Counter output
    logic err;                     // Illegal count written
  } cgt_st_t;
  cgt_st_t s_reg, s_next;

  // Kept out of the state struct: rsync_reg runs on the raw reset and drives rst_q_n, the rest come from u_es
  logic [1:0] rsync_reg; // Reset release stages
  logic rst_q_n;   // Released internal reset
  logic c_rise;    // Rising counter clock
  logic c_fall;    // Falling counter clock
  logic g_lvl;     // Gate level at last rising edge
  logic g_trig;    // Trigger caught at last rising edge

  // Decimal aware decrement; zero wraps to the top count
  function automatic logic [CNT_W-1:0] dec1(input logic [CNT_W-1:0] v,
                                            input logic bcd);
    logic [CNT_W-1:0] r;
    logic borrow;
    r = v;
    borrow = 1'b1;
    if (!bcd)
      r = v - `CGT_ONE;
    else
      for (int i = 0; i < `CGT_BCD_DIGITS; i++)
      begin
        if (borrow)
        begin
          if (v[i*4 +: 4] == 4'h0)
            r[i*4 +: 4] = `CGT_BCD_NINE;
          else
          begin
            r[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
            borrow = 1'b0;
          end
        end
      end
    return r;
  endfunction : dec1

  // Level gated modes
  function automatic logic lvl_mode(input cgt_mode_t m);
    return (m == CGT_M0) || (m == CGT_M2) || (m == CGT_M3) ||
           (m == CGT_M4);
  endfunction : lvl_mode

  // Edge triggered modes
  function automatic logic edge_mode(input cgt_mode_t m);
    return (m == CGT_M1) || (m == CGT_M2) || (m == CGT_M3) ||
           (m == CGT_M5);
  endfunction : edge_mode

  // --------------------------------------------------------------
  // Edge and gate detection
  // --------------------------------------------------------------
  cgt_edge_sync u_es (
    .clk_sys(clk_sys),
    .rst_n(rst_q_n),
    .cnt_clk(cnt_clk),
    .gate_in(gate_in),
    .arm_clr(mode_wr),
    .cclk_rise(c_rise),
    .cclk_fall(c_fall),
    .gate_lvl(g_lvl),
    .trig_seen(g_trig)
  );

  // Reset release through two flip-flops
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rsync_reg <= 2'h0;
    else
      rsync_reg <= {rsync_reg[0], 1'b1};
  end
  assign rst_q_n = rsync_reg[1];

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  // Zero means full scale: the decrement from zero gives 65536 or
  // 10000 steps, so the element is loaded with the raw value.
  always_comb
  begin
    s_next = s_reg;
    // Trigger latch persists until a falling clock loads or reloads the count, or a mode write clears it
    if (c_rise && edge_mode(s_reg.mode) && g_trig)
      s_next.armed = 1'b1;
    // Modes 2,3: gate low forces output high at once
    if ((s_reg.mode == CGT_M2 || s_reg.mode == CGT_M3) && !gate_in)
      s_next.out = 1'b1;
    // Falling clock: only place the element changes
    if (c_fall)
    begin
      if (s_reg.have_cnt && (!edge_mode(s_reg.mode) || s_reg.armed ||
          s_reg.mode != CGT_M1 && s_reg.mode != CGT_M5))
      begin
        s_next.cnt = s_reg.init;
        s_next.have_cnt = 1'b0;
        s_next.run = 1'b1;
        s_next.armed = 1'b0;
      end
      else if (s_reg.armed && s_reg.run)
      begin
        s_next.cnt = s_reg.init;
        s_next.armed = 1'b0;
      end
      else if (s_reg.run &&
               (!lvl_mode(s_reg.mode) || g_lvl))
      begin
        if ((s_reg.mode == CGT_M2 || s_reg.mode == CGT_M3) &&
            s_reg.cnt == `CGT_ONE)
        begin
          s_next.cnt = s_reg.init;
          s_next.out = ~s_reg.out;
        end
        else
        begin
          s_next.cnt = dec1(s_reg.cnt, s_reg.bcd);
          if (dec1(s_reg.cnt, s_reg.bcd) == `CGT_ZERO &&
              s_reg.mode != CGT_M2 && s_reg.mode != CGT_M3)
            s_next.out = ~s_reg.out;
        end
      end
    end
    // Count write from host
    if (count_wr)
    begin
      s_next.init = count_val;
      s_next.have_cnt = 1'b1;
      s_next.err = ((s_reg.mode == CGT_M2 || s_reg.mode == CGT_M3) &&
                    count_val == `CGT_ONE);
    end
    // Mode write resets all control at once
    if (mode_wr)
    begin
      s_next.mode = cgt_mode_t'(mode_sel);
      s_next.bcd = bcd_sel;
      s_next.have_cnt = 1'b0;
      s_next.run = 1'b0;
      s_next.armed = 1'b0;
      s_next.err = 1'b0;
      s_next.out = `CGT_OUT_INIT;
    end
  end

  // Register the state
  always_ff @(posedge clk_sys or negedge rst_q_n)
  begin
    if (!rst_q_n)
    begin
      s_reg.mode <= CGT_M0;
      s_reg.bcd <= 1'b0;
      s_reg.init <= `CGT_ZERO;
      s_reg.cnt <= `CGT_ZERO;
      s_reg.have_cnt <= 1'b0;
      s_reg.run <= 1'b0;
      s_reg.armed <= 1'b0;
      s_reg.out <= `CGT_OUT_INIT;
      s_reg.err <= 1'b0;
    end
    else
    begin
      s_reg.mode <= s_next.mode;
      s_reg.bcd <= s_next.bcd;
      s_reg.init <= s_next.init;
      s_reg.cnt <= s_next.cnt;
      s_reg.have_cnt <= s_next.have_cnt;
      s_reg.run <= s_next.run;
      s_reg.armed <= s_next.armed;
      s_reg.out <= s_next.out;
      s_reg.err <= s_next.err;
    end
  end

  assign cnt_out = s_reg.out;
  assign count_now = s_reg.cnt;
  assign count_err = s_reg.err;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  a_mode_reset: assert property (
    @(posedge clk_sys) disable iff (!rst_q_n)
    mode_wr |=> (s_reg.out == `CGT_OUT_INIT && !s_reg.run))
    else $error("mode write did not reset channel");
  a_fall_only: assert property (
    @(posedge clk_sys) disable iff (!rst_q_n)
    !c_fall |=> $stable(s_reg.cnt))
    else $error("count changed off the falling clock");
  a_gate_hold: assert property (
    @(posedge clk_sys) disable iff (!rst_q_n)
    (c_fall && s_reg.run && !s_reg.have_cnt && !s_reg.armed &&
     s_reg.mode == CGT_M0 && !g_lvl) |=> $stable(s_reg.cnt))
    else $error("low gate did not hold count");
  a_bin_wrap: assert property (
    @(posedge clk_sys) disable iff (!rst_q_n)
    (c_fall && s_reg.run && !s_reg.have_cnt && !s_reg.armed &&
     s_reg.mode == CGT_M4 && !s_reg.bcd && g_lvl &&
     s_reg.cnt == `CGT_ZERO) |=> s_reg.cnt == `CGT_BIN_TOP)
    else $error("binary wrap wrong");
  a_bcd_wrap: assert property (
    @(posedge clk_sys) disable iff (!rst_q_n)
    (c_fall && s_reg.run && !s_reg.have_cnt && !s_reg.armed &&
     s_reg.mode == CGT_M4 && s_reg.bcd && g_lvl &&
     s_reg.cnt == `CGT_ZERO) |=> s_reg.cnt == `CGT_BCD_TOP)
    else $error("decimal wrap wrong");
  a_auto_reload: assert property (
    @(posedge clk_sys) disable iff (!rst_q_n)
    (c_fall && s_reg.run && !s_reg.have_cnt && !s_reg.armed && g_lvl &&
     s_reg.mode == CGT_M2 && s_reg.cnt == `CGT_ONE && !mode_wr)
    |=> s_reg.cnt == $past(s_reg.init))
    else $error("periodic reload missing");
  a_bad_count: assert property (
    @(posedge clk_sys) disable iff (!rst_q_n)
    (count_wr && !mode_wr && s_reg.mode == CGT_M3 &&
     count_val == `CGT_ONE) |=> s_reg.err)
    else $error("illegal count not flagged");
endmodule : cgt_counter

// file: bench/cgt_src.sv
// Counter clock and gate source model for the counter channel bench
module cgt_src
(
  // System clock
  input wire logic clk_sys,
  // Lines driven into the channel
  output logic cnt_clk,
  output logic gate_in
);
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------
  // Settings and idle state
  // ------------------------------------------------------------
  // Phase length in system clocks; the channel needs one at least
  localparam int HALF = 3;

  // Clock stands low between bursts, gate starts low
  initial
  begin
    cnt_clk = 1'b0;
    gate_in = 1'b0;
  end

  // ------------------------------------------------------------
  // Line drivers
  // ------------------------------------------------------------
  // Move the clock just after a system edge, then hold one phase
  task automatic clk_to(input logic lvl);
    @(posedge clk_sys);
    #1;
    cnt_clk = lvl;
    repeat (HALF - 1) @(posedge clk_sys);
  endtask : clk_to

  // Whole counter clock pulses, ending low
  task automatic pulses(input int n);
    repeat (n)
    begin
      clk_to(1'b1);
      clk_to(1'b0);
    end
  endtask : pulses

  // Gate level change off the sampling edge
  task automatic gate(input logic lvl);
    @(posedge clk_sys);
    #1;
    gate_in = lvl;
  endtask : gate

  // One system clock of gate high; must still be caught as a trigger
  task automatic blip();
    gate(1'b1);
    gate(1'b0);
  endtask : blip
endmodule : cgt_src

// file: bench/tb_top.sv
// Self-checking bench for the counter channel timing core
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import cgt_pkg::*;

  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic rst_n;
  logic mode_wr;
  logic [2:0] mode_sel;
  logic bcd_sel;
  logic count_wr;
  logic [15:0] count_val;
  logic cnt_clk;
  logic gate_in;
  logic cnt_out;
  logic [15:0] count_now;
  logic count_err;
  int n_fail = 0;
  int cmp_count = 0;

  // One row: mode, decimal, count, pulses, expected count, check, error
  typedef struct packed {
    logic [2:0] m;
    logic b;
    logic [15:0] v;
    logic [3:0] n;
    logic [15:0] e;
    logic ck;
    logic r;
  } cgt_row_t;

  localparam cgt_row_t ROWS [10] = '{
    '{3'h0, 1'b0, 16'h0003, 4'h2, 16'h0002, 1'b1, 1'b0},
    '{3'h0, 1'b0, 16'h0000, 4'h2, 16'hFFFF, 1'b1, 1'b0},
    '{3'h0, 1'b1, 16'h0000, 4'h2, 16'h9999, 1'b1, 1'b0},
    '{3'h4, 1'b0, 16'h0001, 4'h3, 16'hFFFF, 1'b1, 1'b0},
    '{3'h4, 1'b1, 16'h0001, 4'h3, 16'h9999, 1'b1, 1'b0},
    '{3'h2, 1'b0, 16'h0003, 4'h4, 16'h0003, 1'b1, 1'b0},
    '{3'h2, 1'b0, 16'h0001, 4'h1, 16'h0000, 1'b0, 1'b1},
    '{3'h3, 1'b0, 16'h0002, 4'h1, 16'h0002, 1'b1, 1'b0},
    '{3'h5, 1'b0, 16'h0004, 4'h2, 16'h0003, 1'b1, 1'b0},
    '{3'h1, 1'b1, 16'h0010, 4'h2, 16'h0009, 1'b1, 1'b0}
  };

  // ------------------------------------------------------------
  // Clock, design and source model
  // ------------------------------------------------------------
  always #5 clk_sys = ~clk_sys;

  cgt_counter i_dut (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .mode_wr(mode_wr),
    .mode_sel(mode_sel),
    .bcd_sel(bcd_sel),
    .count_wr(count_wr),
    .count_val(count_val),
    .cnt_clk(cnt_clk),
    .gate_in(gate_in),
    .cnt_out(cnt_out),
    .count_now(count_now),
    .count_err(count_err)
  );

  cgt_src i_src (
    .clk_sys(clk_sys),
    .cnt_clk(cnt_clk),
    .gate_in(gate_in)
  );

  // ------------------------------------------------------------
  // Helper tasks
  // ------------------------------------------------------------
  // Count load shows two system clocks after the fall
  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : settle

  // Single-cycle strobes, released before any next request
  task automatic wr_mode(input logic [2:0] m, input logic b);
    @(posedge clk_sys);
    #1;
    mode_wr = 1'b1;
    mode_sel = m;
    bcd_sel = b;
    @(posedge clk_sys);
    #1;
    mode_wr = 1'b0;
  endtask : wr_mode

  task automatic wr_count(input logic [15:0] v);
    @(posedge clk_sys);
    #1;
    count_wr = 1'b1;
    count_val = v;
    @(posedge clk_sys);
    #1;
    count_wr = 1'b0;
  endtask : wr_count

  // Count compare; flags go through chk_bit
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Flag compare: one bit against its expected level
  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  // ------------------------------------------------------------
  // Watchdog: whole run is a few hundred cycles
  // ------------------------------------------------------------
  initial
  begin
    #100us;
    n_fail++;
    end_sim();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    // Idle inputs, reset held from time zero
    rst_n = 1'b0;
    mode_wr = 1'b0;
    mode_sel = 3'h0;
    bcd_sel = 1'b0;
    count_wr = 1'b0;
    count_val = 16'h0000;
    repeat (5) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    chk_bit(cnt_out, 1'b1);
    chk(count_now, 16'h0000);
    chk_bit(count_err, 1'b0);
    $display("reset test done");
    // Rising counter clock alone must not load
    wr_mode(3'h0, 1'b0);
    wr_count(16'h0007);
    i_src.gate(1'b1);
    i_src.clk_to(1'b1);
    repeat (6) @(posedge clk_sys);
    #1;
    chk(count_now, 16'h0000);
    i_src.clk_to(1'b0);
    settle();
    chk(count_now, 16'h0007);
    // Gate low holds the count, gate high resumes
    i_src.gate(1'b0);
    i_src.pulses(3);
    settle();
    chk(count_now, 16'h0007);
    i_src.gate(1'b1);
    i_src.pulses(1);
    settle();
    chk(count_now, 16'h0006);
    $display("gate level test done");
    // Output flips at zero; mode write restores it without clocks
    wr_mode(3'h0, 1'b0);
    wr_count(16'h0001);
    i_src.pulses(2);
    settle();
    chk_bit(cnt_out, 1'b0);
    wr_mode(3'h0, 1'b0);
    chk_bit(cnt_out, 1'b1);
    $display("mode write test done");
    // Short trigger between counter clock edges
    i_src.gate(1'b0);
    wr_mode(3'h1, 1'b0);
    wr_count(16'h0005);
    i_src.blip();
    i_src.pulses(2);
    settle();
    chk(count_now, 16'h0004);
    $display("short trigger test done");
    // Table of ordinary cases, gate raised after each count write
    for (int i = 0; i < 10; i++)
    begin
      i_src.gate(1'b0);
      wr_mode(ROWS[i].m, ROWS[i].b);
      wr_count(ROWS[i].v);
      i_src.gate(1'b1);
      i_src.pulses(int'(ROWS[i].n));
      settle();
      if (ROWS[i].ck)
        chk(count_now, ROWS[i].e);
      chk_bit(count_err, ROWS[i].r);
      $display("row test %0d done", i);
    end
    // Reset in mid-run with a flagged count still waiting to load
    wr_mode(3'h2, 1'b0);
    wr_count(16'h0001);
    chk_bit(count_err, 1'b1);
    i_src.gate(1'b0);
    rst_n = 1'b0;
    #1;
    chk_bit(cnt_out, 1'b1);
    chk(count_now, 16'h0000);
    chk_bit(count_err, 1'b0);
    repeat (5) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    // Channel must count again after the release
    wr_mode(3'h0, 1'b0);
    wr_count(16'h0002);
    i_src.gate(1'b1);
    i_src.pulses(2);
    settle();
    chk(count_now, 16'h0001);
    $display("mid-run reset test done");
    end_sim();
  end
endmodule : tb_top
